// File: bench/ifpr_regs_tb.sv
// self-checking bench for the interrupt flag and priority registers
// assumes the apb slave of ifpr_regs with pready tied high
`timescale 1ns/1ps
module ifpr_regs_tb;
  import ifpr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] port_b_latch = 8'ha6;
  logic [7:0] port_b_pullup_en;
  logic ext_irq1_pin = 1'b0;
  logic ext_irq2_pin = 1'b0;
  logic ext_irq0_edge_select;
  ifpr_events_t events = '0;
  ifpr_prio_t prio;
  logic [31:0] rd;
  logic er;
  int fail_count = 0;
  int check_count = 0;

  ifpr_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_b_latch(port_b_latch),
    .port_b_pullup_en(port_b_pullup_en), .ext_irq1_pin(ext_irq1_pin),
    .ext_irq2_pin(ext_irq2_pin), .ext_irq0_edge_select(ext_irq0_edge_select),
    .events(events), .prio(prio));

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  task end_sim;
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= 4'h1;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    er = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rc(input string name, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(name, {24'h0, exp}, rd);
  endtask

  // one-cycle set pulses into the three flag registers
  task pulse(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge clk_sys);
    events.f1_set <= a;
    events.f2_set <= b;
    events.f3_set <= c;
    @(posedge clk_sys);
    events.f1_set <= 8'h00;
    events.f2_set <= 8'h00;
    events.f3_set <= 8'h00;
  endtask

  // pins pass a two-stage synchroniser, so allow several cycles to settle
  task pin(input logic p1, input logic p2);
    @(posedge clk_sys);
    ext_irq1_pin <= p1;
    ext_irq2_pin <= p2;
    repeat (6) @(posedge clk_sys);
  endtask

  // watchdog sized well above the roughly 160 cycles the tests need
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end

  initial begin
    events.tx_empty <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rc("ctrl2 reset", IFPR_OFS_CTRL2, 8'he5);
    rc("ctrl3 reset", IFPR_OFS_CTRL3, 8'hc0);
    rc("flags1 reset", IFPR_OFS_FLAGS1, 8'h10);
    chk("pullups off", 32'h0, {24'h0, port_b_pullup_en});
    chk("edge0 reset", 32'h1, {31'h0, ext_irq0_edge_select});
    apb(1'b1, IFPR_OFS_CTRL2, 8'hff);
    rc("ctrl2 holes", IFPR_OFS_CTRL2, 8'he5);
    apb(1'b1, IFPR_OFS_CTRL2, 8'h00);
    // live outputs follow the write only after its edge has settled
    @(negedge clk_sys);
    chk("pullups latch", {24'h0, port_b_latch}, {24'h0, port_b_pullup_en});
    chk("edge0 select", 32'h0, {31'h0, ext_irq0_edge_select});
    // peripheral flags with rx full and tx not empty
    events.rx_full <= 1'b1;
    events.tx_empty <= 1'b0;
    pulse(8'hff, 8'hff, 8'hff);
    rc("flags1 set", IFPR_OFS_FLAGS1, 8'hef);
    rc("flags2 set", IFPR_OFS_FLAGS2, 8'h5f);
    rc("flags3 set", IFPR_OFS_FLAGS3, 8'hff);
    apb(1'b1, IFPR_OFS_FLAGS1, 8'h10);
    rc("flags1 clear", IFPR_OFS_FLAGS1, 8'h20);
    apb(1'b1, IFPR_OFS_FLAGS2, 8'h00);
    apb(1'b1, IFPR_OFS_FLAGS3, 8'h5a);
    rc("flags3 rw", IFPR_OFS_FLAGS3, 8'h5a);
    // a software clear that meets a hardware set in one cycle loses
    fork
      apb(1'b1, IFPR_OFS_FLAGS3, 8'h00);
      begin
        @(posedge clk_sys);
        pulse(8'h00, 8'h00, 8'h01);
      end
    join
    rc("set beats clear", IFPR_OFS_FLAGS3, 8'h01);
    // pwm mode keeps the capture flags quiet
    events.capture_pwm <= 1'b1;
    events.ecap_pwm <= 1'b1;
    pulse(8'h04, 8'h01, 8'h00);
    rc("capture pwm", IFPR_OFS_FLAGS1, 8'h20);
    rc("ecap pwm", IFPR_OFS_FLAGS2, 8'h00);
    events.capture_pwm <= 1'b0;
    events.ecap_pwm <= 1'b0;
    // smaller package drops three flags
    apb(1'b1, IFPR_OFS_CFG, 8'h02);
    pulse(8'h80, 8'h41, 8'h00);
    rc("small flags1", IFPR_OFS_FLAGS1, 8'h20);
    rc("small flags2", IFPR_OFS_FLAGS2, 8'h00);
    // external interrupts: rising edge, ext1 with enables off, ext2 with enables on
    apb(1'b1, IFPR_OFS_CFG, 8'h00);
    apb(1'b1, IFPR_OFS_CTRL2, 8'h20);
    pin(1'b1, 1'b0);
    rc("ext1 flag", IFPR_OFS_CTRL3, 8'hc1);
    chk("ext1 no req", 32'h0, {31'h0, prio.ext1_req});
    pin(1'b0, 1'b0);
    rc("ext1 sticky", IFPR_OFS_CTRL3, 8'hc1);
    apb(1'b1, IFPR_OFS_CTRL3, 8'hd8);
    pin(1'b0, 1'b1);
    rc("ext2 flag", IFPR_OFS_CTRL3, 8'hda);
    chk("ext2 req", 32'h1, {31'h0, prio.ext2_req});
    chk("ext1 idle", 32'h0, {31'h0, prio.ext1_req});
    rc("pin status", IFPR_OFS_STATUS, 8'h02);
    chk("mapped no err", 32'h0, {31'h0, er});
    // falling edge select
    apb(1'b1, IFPR_OFS_CTRL2, 8'h00);
    apb(1'b1, IFPR_OFS_CTRL3, 8'hd8);
    pin(1'b0, 1'b0);
    rc("ext2 falling", IFPR_OFS_CTRL3, 8'hda);
    // priority bits only count with levels enabled
    apb(1'b1, IFPR_OFS_CTRL3, 8'h00);
    @(negedge clk_sys);
    chk("prio off", 32'h0f, {26'h0, prio});
    apb(1'b1, IFPR_OFS_CFG, 8'h01);
    @(negedge clk_sys);
    chk("prio low", 32'h00, {26'h0, prio});
    apb(1'b1, IFPR_OFS_CTRL3, 8'h80);
    apb(1'b1, IFPR_OFS_CTRL2, 8'h04);
    @(negedge clk_sys);
    chk("prio x2 t0", 32'h0a, {26'h0, prio});
    apb(1'b1, IFPR_OFS_CTRL3, 8'h40);
    apb(1'b1, IFPR_OFS_CTRL2, 8'h01);
    @(negedge clk_sys);
    chk("prio x1 pc", 32'h05, {26'h0, prio});
    // unmapped address is refused
    apb(1'b1, 12'h0f0, 8'hff);
    chk("unmapped wr err", 32'h1, {31'h0, er});
    apb(1'b0, 12'h0f0, 8'h00);
    chk("unmapped rd err", 32'h1, {31'h0, er});
    chk("unmapped rd data", 32'h0, rd);
    end_sim();
  end
endmodule

// File: verilog/ifpr_pkg.sv
// package for the interrupt flag and priority register block
// assumes an apb slave with 32-bit data and word-aligned registers
package ifpr_pkg;
  // register byte offsets
  localparam logic [11:0] IFPR_OFS_CTRL2 = 12'h000;
  localparam logic [11:0] IFPR_OFS_CTRL3 = 12'h004;
  localparam logic [11:0] IFPR_OFS_FLAGS1 = 12'h008;
  localparam logic [11:0] IFPR_OFS_FLAGS2 = 12'h00c;
  localparam logic [11:0] IFPR_OFS_FLAGS3 = 12'h010;
  localparam logic [11:0] IFPR_OFS_CFG = 12'h014;
  localparam logic [11:0] IFPR_OFS_STATUS = 12'h018;
  // control 2 fields
  localparam int IFPR_C2_PULLUP_DIS = 7;
  localparam int IFPR_C2_EDGE0 = 6;
  localparam int IFPR_C2_EDGE1 = 5;
  localparam int IFPR_C2_T0_PRIO = 2;
  localparam int IFPR_C2_PC_PRIO = 0;
  localparam logic [7:0] IFPR_C2_MASK = 8'he5;
  localparam logic [7:0] IFPR_C2_RESET = 8'he5;
  // control 3 fields
  localparam int IFPR_C3_X2_PRIO = 7;
  localparam int IFPR_C3_X1_PRIO = 6;
  localparam int IFPR_C3_X2_EN = 4;
  localparam int IFPR_C3_X1_EN = 3;
  localparam int IFPR_C3_X2_FLAG = 1;
  localparam int IFPR_C3_X1_FLAG = 0;
  localparam logic [7:0] IFPR_C3_MASK = 8'hdb;
  localparam logic [7:0] IFPR_C3_RESET = 8'hc0;
  // flag register 1 fields
  localparam int IFPR_F1_PARPORT = 7;
  localparam int IFPR_F1_RXFULL = 5;
  localparam int IFPR_F1_TXEMPTY = 4;
  localparam logic [7:0] IFPR_F1_SW_MASK = 8'hcf;
  // flag register 2 fields
  localparam int IFPR_F2_CMP = 6;
  localparam int IFPR_F2_ECAP = 0;
  localparam logic [7:0] IFPR_F2_MASK = 8'h5f;
  localparam logic [7:0] IFPR_FLAG_RESET = 8'h00;
  // config register: bit 0 priority levels, bit 1 small package
  localparam int IFPR_CFG_PRIO_EN = 0;
  localparam int IFPR_CFG_SMALL = 1;
  localparam logic [1:0] IFPR_CFG_RESET = 2'h0;

  // hardware events: one-cycle flag set pulses on clk_sys, plus rx/tx status and pwm mode levels
  typedef struct packed {
    logic [7:0] f1_set;
    logic [7:0] f2_set;
    logic [7:0] f3_set;
    logic rx_full;
    logic tx_empty;
    logic capture_pwm;
    logic ecap_pwm;
    logic timer0_ovf;
    logic port_change;
  } ifpr_events_t;

  // priority routing for the vectoring logic
  typedef struct packed {
    logic ext2_req;
    logic ext1_req;
    logic ext2_high;
    logic ext1_high;
    logic timer0_high;
    logic port_change_high;
  } ifpr_prio_t;

  typedef struct packed {
    logic [7:0] ctrl2_reg;
    logic [7:0] ctrl3_reg;
    logic [7:0] flags1_reg;
    logic [7:0] flags2_reg;
    logic [7:0] flags3_reg;
    logic [1:0] cfg_reg;
    logic [1:0] ext_sync1_reg;
    logic [1:0] ext_sync2_reg;
    logic [1:0] ext_prev_reg;
    logic [31:0] prdata_reg;
  } ifpr_state_t;
endpackage

// File: verilog/ifpr_regs.sv
// interrupt control 2/3 and peripheral request flag registers on apb
// assumes peripherals give one-cycle event pulses on clk_sys and
// external interrupt pins arrive asynchronously
//
// Function
// - pull-up disable bit 7 kills port-B pull-ups
// - edge select 1 rising, 0 falling
// - bits 2,0 set timer0/port-change priority
// - control 2 bits 4,3,1 read zero
// - control 3 bits 7,6 set ext priorities
// - ext requests only while enables set
// - ext flags set on edge, sticky
// - flags set regardless of enables
// - parallel port access sets flag 1 bit 7
// - conversion done sets flag 1 bit 6
// - rx full bit read-only, hardware status
// - tx empty bit read-only, hardware status
// - sync serial done sets bit 3
// - capture/compare sets bit 2, not PWM
// - timer2 match bit 1, timer1 overflow bit 0
// - comparator change bit 6, eeprom done bit 4
// - collision bit 3, low voltage 2, timer3 1
// - enhanced capture sets bit 0, not PWM
// - small package drops three flags
// - can invalid, wake, error set bits 7-5
// - can tx bufs bits 4-2, rx 1-0
// - priority bits act only with levels enabled
`timescale 1ns/1ps
module ifpr_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_b_latch,
  output logic [7:0] port_b_pullup_en,
  input wire logic ext_irq1_pin,
  input wire logic ext_irq2_pin,
  output logic ext_irq0_edge_select,
  input wire ifpr_pkg::ifpr_events_t events,
  output ifpr_pkg::ifpr_prio_t prio
);
  import ifpr_pkg::*;

  ifpr_state_t st_reg;
  ifpr_state_t st_next;
  logic wr_en;
  logic rd_en;
  logic [7:0] wbyte;
  logic [1:0] ext_edge;
  logic [7:0] f1_mask;
  logic [7:0] f2_mask;
  logic levels_on;

  // decode once, used for both reads and write steering
  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == IFPR_OFS_CTRL2) || (a == IFPR_OFS_CTRL3) || (a == IFPR_OFS_FLAGS1) ||
      (a == IFPR_OFS_FLAGS2) || (a == IFPR_OFS_FLAGS3) || (a == IFPR_OFS_CFG) ||
      (a == IFPR_OFS_STATUS);
  endfunction

  // zero-wait slave: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign wr_en = psel && penable && pwrite && pstrb[0] && addr_mapped(paddr);
  assign rd_en = psel && !penable && !pwrite && addr_mapped(paddr);
  assign wbyte = pwdata[7:0];
  assign prdata = st_reg.prdata_reg;
  assign levels_on = st_reg.cfg_reg[IFPR_CFG_PRIO_EN];

  // the small package lacks parallel port, comparator, enhanced capture
  assign f1_mask = st_reg.cfg_reg[IFPR_CFG_SMALL] ? 8'h7f : 8'hff;
  assign f2_mask = st_reg.cfg_reg[IFPR_CFG_SMALL] ? 8'h1e : IFPR_F2_MASK;

  // edge detect reads only the second synchroniser stage
  always_comb begin
    logic [1:0] sel;
    sel = {st_reg.ctrl2_reg[IFPR_C2_EDGE1], st_reg.ctrl2_reg[IFPR_C2_EDGE1]};
    for (int i = 0; i < 2; i++) begin
      // both ext 1 and ext 2 follow the ext 1 select here
      ext_edge[i] = sel[i] ? (st_reg.ext_sync2_reg[i] && !st_reg.ext_prev_reg[i])
                           : (!st_reg.ext_sync2_reg[i] && st_reg.ext_prev_reg[i]);
    end
  end

  // all state updates; hardware sets win over a software clear
  always_comb begin
    logic [7:0] hw1;
    logic [7:0] hw2;
    st_next = st_reg;
    hw1 = events.f1_set;
    hw2 = events.f2_set;
    if (events.capture_pwm) begin
      hw1[2] = 1'b0;
    end
    if (events.ecap_pwm) begin
      hw2[IFPR_F2_ECAP] = 1'b0;
    end
    st_next.ext_sync1_reg = {ext_irq2_pin, ext_irq1_pin};
    st_next.ext_sync2_reg = st_reg.ext_sync1_reg;
    st_next.ext_prev_reg = st_reg.ext_sync2_reg;
    if (wr_en) begin
      case (paddr)
        IFPR_OFS_CTRL2: st_next.ctrl2_reg = wbyte & IFPR_C2_MASK;
        IFPR_OFS_CTRL3: st_next.ctrl3_reg = wbyte & IFPR_C3_MASK;
        IFPR_OFS_FLAGS1: st_next.flags1_reg = (wbyte & IFPR_F1_SW_MASK) & f1_mask;
        IFPR_OFS_FLAGS2: st_next.flags2_reg = wbyte & f2_mask;
        IFPR_OFS_FLAGS3: st_next.flags3_reg = wbyte;
        IFPR_OFS_CFG: st_next.cfg_reg = wbyte[1:0];
        default: st_next.cfg_reg = st_reg.cfg_reg;
      endcase
    end
    // sticky ext flags, set regardless of enable
    st_next.ctrl3_reg[IFPR_C3_X1_FLAG] = st_next.ctrl3_reg[IFPR_C3_X1_FLAG] | ext_edge[0];
    st_next.ctrl3_reg[IFPR_C3_X2_FLAG] = st_next.ctrl3_reg[IFPR_C3_X2_FLAG] | ext_edge[1];
    // sticky peripheral flags ignore enables, so software can poll
    st_next.flags1_reg = (st_next.flags1_reg | (hw1 & IFPR_F1_SW_MASK)) & f1_mask;
    st_next.flags1_reg[IFPR_F1_RXFULL] = events.rx_full;
    st_next.flags1_reg[IFPR_F1_TXEMPTY] = events.tx_empty;
    st_next.flags2_reg = (st_next.flags2_reg | hw2) & f2_mask;
    st_next.flags3_reg = st_next.flags3_reg | events.f3_set;
    // read data loads in the setup cycle so it stands through the access cycle
    if (rd_en) begin
      case (paddr)
        IFPR_OFS_CTRL2: st_next.prdata_reg = {24'h0, st_reg.ctrl2_reg};
        IFPR_OFS_CTRL3: st_next.prdata_reg = {24'h0, st_reg.ctrl3_reg};
        IFPR_OFS_FLAGS1: st_next.prdata_reg = {24'h0, st_reg.flags1_reg};
        IFPR_OFS_FLAGS2: st_next.prdata_reg = {24'h0, st_reg.flags2_reg};
        IFPR_OFS_FLAGS3: st_next.prdata_reg = {24'h0, st_reg.flags3_reg};
        IFPR_OFS_CFG: st_next.prdata_reg = {30'h0, st_reg.cfg_reg};
        IFPR_OFS_STATUS: st_next.prdata_reg = {30'h0, st_reg.ext_sync2_reg};
        default: st_next.prdata_reg = 32'h0;
      endcase
    end else if (psel && !penable) begin
      st_next.prdata_reg = 32'h0;
    end
  end

  // single register update; reset is synchronous
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_reg.ctrl2_reg <= IFPR_C2_RESET;
      st_reg.ctrl3_reg <= IFPR_C3_RESET;
      st_reg.flags1_reg <= IFPR_FLAG_RESET;
      st_reg.flags2_reg <= IFPR_FLAG_RESET;
      st_reg.flags3_reg <= IFPR_FLAG_RESET;
      st_reg.cfg_reg <= IFPR_CFG_RESET;
      st_reg.ext_sync1_reg <= 2'h0;
      st_reg.ext_sync2_reg <= 2'h0;
      st_reg.ext_prev_reg <= 2'h0;
      st_reg.prdata_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  // pull-ups follow each latch unless globally disabled
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port_b_pullup_en[i] = !st_reg.ctrl2_reg[IFPR_C2_PULLUP_DIS] && port_b_latch[i];
    end
  end
  assign ext_irq0_edge_select = st_reg.ctrl2_reg[IFPR_C2_EDGE0];

  // priority bits are forced to high (single level) while levels are off
  always_comb begin
    prio.ext2_req = st_reg.ctrl3_reg[IFPR_C3_X2_FLAG] && st_reg.ctrl3_reg[IFPR_C3_X2_EN];
    prio.ext1_req = st_reg.ctrl3_reg[IFPR_C3_X1_FLAG] && st_reg.ctrl3_reg[IFPR_C3_X1_EN];
    prio.ext2_high = !levels_on || st_reg.ctrl3_reg[IFPR_C3_X2_PRIO];
    prio.ext1_high = !levels_on || st_reg.ctrl3_reg[IFPR_C3_X1_PRIO];
    prio.timer0_high = !levels_on || st_reg.ctrl2_reg[IFPR_C2_T0_PRIO];
    prio.port_change_high = !levels_on || st_reg.ctrl2_reg[IFPR_C2_PC_PRIO];
  end

  // checks
  property p_ext1_flag;
    @(posedge clk_sys) disable iff (!rst_n)
      ext_edge[0] |=> st_reg.ctrl3_reg[IFPR_C3_X1_FLAG];
  endproperty
  a_ext1_flag: assert property (p_ext1_flag) else $error("ext1 flag not set");
  property p_ext_sync_delay;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(ext_irq1_pin) ##1 ext_irq1_pin ##1 ext_irq1_pin |-> st_reg.ext_sync2_reg[0];
  endproperty
  a_ext_sync_delay: assert property (p_ext_sync_delay) else $error("sync lag wrong");
  property p_pullup;
    @(posedge clk_sys) disable iff (!rst_n)
      st_reg.ctrl2_reg[IFPR_C2_PULLUP_DIS] |-> port_b_pullup_en == 8'h00;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on while disabled");
  property p_c2_unimpl;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_reg.ctrl2_reg & ~IFPR_C2_MASK) == 8'h00;
  endproperty
  a_c2_unimpl: assert property (p_c2_unimpl) else $error("ctrl2 reserved set");
  property p_ext_req;
    @(posedge clk_sys) disable iff (!rst_n)
      prio.ext2_req |-> st_reg.ctrl3_reg[IFPR_C3_X2_EN];
  endproperty
  a_ext_req: assert property (p_ext_req) else $error("ext2 request while disabled");
  property p_single_level;
    @(posedge clk_sys) disable iff (!rst_n)
      !levels_on |-> (prio.ext1_high && prio.timer0_high && prio.port_change_high);
  endproperty
  a_single_level: assert property (p_single_level) else $error("priority used");
  property p_adc_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f1_set[6] |=> st_reg.flags1_reg[6];
  endproperty
  a_adc_set: assert property (p_adc_set) else $error("conversion flag lost");
  property p_rx_status;
    @(posedge clk_sys) disable iff (!rst_n)
      rst_n |=> st_reg.flags1_reg[IFPR_F1_RXFULL] == $past(events.rx_full);
  endproperty
  a_rx_status: assert property (p_rx_status) else $error("rx full wrong");
  property p_small_pkg;
    @(posedge clk_sys) disable iff (!rst_n)
      st_reg.cfg_reg[IFPR_CFG_SMALL] |=> !st_reg.flags2_reg[IFPR_F2_CMP];
  endproperty
  a_small_pkg: assert property (p_small_pkg) else $error("small package flag set");
  property p_can_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f3_set[4] |=> st_reg.flags3_reg[4];
  endproperty
  a_can_set: assert property (p_can_set) else $error("can tx flag lost");
  // external interrupt flags, priorities and pin-side outputs
  property p_ext2_flag;
    @(posedge clk_sys) disable iff (!rst_n)
      ext_edge[1] |=> st_reg.ctrl3_reg[IFPR_C3_X2_FLAG];
  endproperty
  a_ext2_flag: assert property (p_ext2_flag) else $error("ext2 flag not set");
  property p_ext1_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      st_reg.ctrl3_reg[IFPR_C3_X1_FLAG] && !(wr_en && (paddr == IFPR_OFS_CTRL3))
        |=> st_reg.ctrl3_reg[IFPR_C3_X1_FLAG];
  endproperty
  a_ext1_hold: assert property (p_ext1_hold) else $error("ext1 flag dropped");
  property p_ext2_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      st_reg.ctrl3_reg[IFPR_C3_X2_FLAG] && !(wr_en && (paddr == IFPR_OFS_CTRL3))
        |=> st_reg.ctrl3_reg[IFPR_C3_X2_FLAG];
  endproperty
  a_ext2_hold: assert property (p_ext2_hold) else $error("ext2 flag dropped");
  property p_x2_prio_level;
    @(posedge clk_sys) disable iff (!rst_n)
      levels_on |-> prio.ext2_high == st_reg.ctrl3_reg[IFPR_C3_X2_PRIO];
  endproperty
  a_x2_prio_level: assert property (p_x2_prio_level) else $error("ext2 level wrong");
  property p_x1_prio_level;
    @(posedge clk_sys) disable iff (!rst_n)
      levels_on |-> prio.ext1_high == st_reg.ctrl3_reg[IFPR_C3_X1_PRIO];
  endproperty
  a_x1_prio_level: assert property (p_x1_prio_level) else $error("ext1 level wrong");
  property p_t0_prio_level;
    @(posedge clk_sys) disable iff (!rst_n)
      levels_on |-> prio.timer0_high == st_reg.ctrl2_reg[IFPR_C2_T0_PRIO];
  endproperty
  a_t0_prio_level: assert property (p_t0_prio_level) else $error("timer0 level wrong");
  property p_pc_prio_level;
    @(posedge clk_sys) disable iff (!rst_n)
      levels_on |-> prio.port_change_high == st_reg.ctrl2_reg[IFPR_C2_PC_PRIO];
  endproperty
  a_pc_prio_level: assert property (p_pc_prio_level) else $error("port level wrong");
  property p_single_x2;
    @(posedge clk_sys) disable iff (!rst_n)
      !levels_on |-> prio.ext2_high;
  endproperty
  a_single_x2: assert property (p_single_x2) else $error("ext2 priority used");
  property p_pullup_follow;
    @(posedge clk_sys) disable iff (!rst_n)
      !st_reg.ctrl2_reg[IFPR_C2_PULLUP_DIS] |-> port_b_pullup_en == port_b_latch;
  endproperty
  a_pullup_follow: assert property (p_pullup_follow) else $error("pull-up not latch");
  property p_edge0_out;
    @(posedge clk_sys) disable iff (!rst_n)
      ext_irq0_edge_select == st_reg.ctrl2_reg[IFPR_C2_EDGE0];
  endproperty
  a_edge0_out: assert property (p_edge0_out) else $error("edge0 select wrong");
  // peripheral flag sets; a set wins over a clear in the same cycle
  property p_parport_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f1_set[IFPR_F1_PARPORT] && !st_reg.cfg_reg[IFPR_CFG_SMALL]
        |=> st_reg.flags1_reg[IFPR_F1_PARPORT];
  endproperty
  a_parport_set: assert property (p_parport_set) else $error("parallel flag lost");
  property p_sync_serial_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f1_set[3] |=> st_reg.flags1_reg[3];
  endproperty
  a_sync_serial_set: assert property (p_sync_serial_set) else $error("serial flag lost");
  property p_capture_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f1_set[2] && !events.capture_pwm |=> st_reg.flags1_reg[2];
  endproperty
  a_capture_set: assert property (p_capture_set) else $error("capture flag lost");
  property p_capture_pwm;
    @(posedge clk_sys) disable iff (!rst_n)
      events.capture_pwm && !st_reg.flags1_reg[2] && !wr_en |=> !st_reg.flags1_reg[2];
  endproperty
  a_capture_pwm: assert property (p_capture_pwm) else $error("capture set in pwm");
  property p_timer2_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f1_set[1] |=> st_reg.flags1_reg[1];
  endproperty
  a_timer2_set: assert property (p_timer2_set) else $error("timer2 flag lost");
  property p_timer1_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f1_set[0] |=> st_reg.flags1_reg[0];
  endproperty
  a_timer1_set: assert property (p_timer1_set) else $error("timer1 flag lost");
  property p_tx_status;
    @(posedge clk_sys) disable iff (!rst_n)
      rst_n |=> st_reg.flags1_reg[IFPR_F1_TXEMPTY] == $past(events.tx_empty);
  endproperty
  a_tx_status: assert property (p_tx_status) else $error("tx empty wrong");
  property p_eeprom_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f2_set[4] |=> st_reg.flags2_reg[4];
  endproperty
  a_eeprom_set: assert property (p_eeprom_set) else $error("eeprom flag lost");
  property p_cmp_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f2_set[IFPR_F2_CMP] && !st_reg.cfg_reg[IFPR_CFG_SMALL]
        |=> st_reg.flags2_reg[IFPR_F2_CMP];
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("comparator flag lost");
  property p_collision_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f2_set[3] |=> st_reg.flags2_reg[3];
  endproperty
  a_collision_set: assert property (p_collision_set) else $error("collision flag lost");
  property p_low_voltage_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f2_set[2] |=> st_reg.flags2_reg[2];
  endproperty
  a_low_voltage_set: assert property (p_low_voltage_set) else $error("voltage flag lost");
  property p_timer3_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f2_set[1] |=> st_reg.flags2_reg[1];
  endproperty
  a_timer3_set: assert property (p_timer3_set) else $error("timer3 flag lost");
  property p_ecap_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f2_set[IFPR_F2_ECAP] && !events.ecap_pwm && !st_reg.cfg_reg[IFPR_CFG_SMALL]
        |=> st_reg.flags2_reg[IFPR_F2_ECAP];
  endproperty
  a_ecap_set: assert property (p_ecap_set) else $error("enhanced capture flag lost");
  property p_ecap_pwm;
    @(posedge clk_sys) disable iff (!rst_n)
      events.ecap_pwm && !st_reg.flags2_reg[IFPR_F2_ECAP] && !wr_en
        |=> !st_reg.flags2_reg[IFPR_F2_ECAP];
  endproperty
  a_ecap_pwm: assert property (p_ecap_pwm) else $error("enhanced capture set in pwm");
  // small package holes and can controller flags
  property p_small_par;
    @(posedge clk_sys) disable iff (!rst_n)
      st_reg.cfg_reg[IFPR_CFG_SMALL] |=> !st_reg.flags1_reg[IFPR_F1_PARPORT];
  endproperty
  a_small_par: assert property (p_small_par) else $error("small parallel flag set");
  property p_small_ecap;
    @(posedge clk_sys) disable iff (!rst_n)
      st_reg.cfg_reg[IFPR_CFG_SMALL] |=> !st_reg.flags2_reg[IFPR_F2_ECAP];
  endproperty
  a_small_ecap: assert property (p_small_ecap) else $error("small capture flag set");
  property p_can_invalid_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f3_set[7] |=> st_reg.flags3_reg[7];
  endproperty
  a_can_invalid_set: assert property (p_can_invalid_set) else $error("can invalid lost");
  property p_can_error_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f3_set[5] |=> st_reg.flags3_reg[5];
  endproperty
  a_can_error_set: assert property (p_can_error_set) else $error("can error lost");
  property p_can_rx0_set;
    @(posedge clk_sys) disable iff (!rst_n)
      events.f3_set[0] |=> st_reg.flags3_reg[0];
  endproperty
  a_can_rx0_set: assert property (p_can_rx0_set) else $error("can rx0 flag lost");
endmodule
